// File: rtl/line_irq_pkg.sv
// constants and carrier types for the line event interrupt status block
package line_irq_pkg;
    // register map, byte offsets on the plain port
    localparam logic [11:0] ADDR_LIVE_ONE = 12'h7e1;
    localparam logic [11:0] ADDR_LINE_FLAGS = 12'h7e2;
    localparam logic [11:0] ADDR_CODE_FLAGS = 12'h7e0;
    localparam logic [11:0] ADDR_CODE_ENABLE = 12'h7e8;
    localparam logic [11:0] ADDR_LINE_ENABLE = 12'h7e9;
    localparam logic [11:0] ADDR_CONFIG = 12'h7ea;
    // field positions in the second status register
    localparam int BIT_COUNT_OVF = 0;
    localparam int BIT_PATTERN_ERR = 1;
    localparam int BIT_LINE_ZEROS = 2;
    localparam int BIT_SYS_ZEROS = 3;
    localparam int BIT_LINE_VIOL = 4;
    localparam int BIT_SYS_VIOL = 5;
    localparam int LINE_FLAG_COUNT = 6;
    // field positions for the inband code flags
    localparam int BIT_DEACT_CODE = 0;
    localparam int BIT_ACT_CODE = 1;
    localparam int CODE_FLAG_COUNT = 2;
    // configuration register field
    localparam int BIT_EDGE_SELECT = 0;
    // reset values
    localparam logic [7:0] RESET_FLAGS = 8'h00;
    localparam logic [7:0] RESET_ENABLE = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;

    // live detector inputs grouped together
    typedef struct packed {
        logic activate_code_live;
        logic deactivate_code_live;
        logic system_violation;
        logic line_violation;
        logic system_zeros;
        logic line_zeros;
        logic pattern_error;
    } line_events_t;

    // register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_t;
endpackage

// File: rtl/line_event_interrupt_status.sv
// interrupt status latches for inband codes and line error events
//
// Contract
// - activate code flag latches on a rise of its live bit, or any edge if edge select is set, and drives the interrupt.
// - deactivate code flag latches on a rise of its live bit, or any edge if edge select is set, and drives the interrupt.
// - bit five of the second status register latches system-side bipolar violations.
// - bit four of the second status register latches line-side bipolar violations.
// - bit three of the second status register latches system-side excessive zeros.
// - bit two of the second status register latches line-side excessive zeros.
// - bit one of the second status register latches pattern checker bit errors.
// - bit zero of the second status register latches a wrap of the sixteen-bit error counter.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module line_event_interrupt_status #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire line_irq_pkg::line_events_t events_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o
);

    // live inputs come from another domain: two flops each
    line_irq_pkg::line_events_t sync1_q;
    line_irq_pkg::line_events_t sync2_q;
    line_irq_pkg::line_events_t prev_q;
    line_irq_pkg::reg_req_t req;

    logic [line_irq_pkg::CODE_FLAG_COUNT-1:0] code_flags_q;
    logic [line_irq_pkg::CODE_FLAG_COUNT-1:0] code_set;
    logic [line_irq_pkg::CODE_FLAG_COUNT-1:0] code_clr;
    logic [line_irq_pkg::CODE_FLAG_COUNT-1:0] code_live;
    logic [line_irq_pkg::CODE_FLAG_COUNT-1:0] code_prev;
    logic [line_irq_pkg::LINE_FLAG_COUNT-1:0] line_flags_q;
    logic [line_irq_pkg::LINE_FLAG_COUNT-1:0] line_set;
    logic [line_irq_pkg::LINE_FLAG_COUNT-1:0] line_clr;
    logic [7:0] code_enable_q;
    logic [7:0] line_enable_q;
    logic edge_select_q;
    logic [COUNT_WIDTH-1:0] error_count_q;
    logic count_wrap;
    logic [7:0] rdata_d;

    // decoding of a write to one register, used for every write target
    function automatic logic hit_write(
        input line_irq_pkg::reg_req_t r,
        input logic [11:0] a
    );
        hit_write = r.write && (r.addr == a);
    endfunction

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   write: reg_write_i, read: reg_read_i};

    // synchroniser; only the second stage feeds the edge detectors
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            sync1_q <= events_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // configuration and enable registers
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            edge_select_q <= 1'b0;
            code_enable_q <= line_irq_pkg::RESET_ENABLE;
            line_enable_q <= line_irq_pkg::RESET_ENABLE;
        end
        else
        begin
            if (hit_write(req, line_irq_pkg::ADDR_CONFIG))
            begin
                edge_select_q <= req.wdata[line_irq_pkg::BIT_EDGE_SELECT];
            end
            if (hit_write(req, line_irq_pkg::ADDR_CODE_ENABLE))
            begin
                code_enable_q <= req.wdata;
            end
            if (hit_write(req, line_irq_pkg::ADDR_LINE_ENABLE))
            begin
                line_enable_q <= req.wdata;
            end
        end
    end

    // pattern error counter; wrap to zero marks an overflow
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            error_count_q <= COUNT_WIDTH'(line_irq_pkg::RESET_COUNT);
        end
        else if (sync2_q.pattern_error && !prev_q.pattern_error)
        begin
            error_count_q <= error_count_q + COUNT_WIDTH'(1);
        end
    end

    assign count_wrap = sync2_q.pattern_error && !prev_q.pattern_error
                        && (&error_count_q);

    assign code_live = {sync2_q.activate_code_live,
                        sync2_q.deactivate_code_live};
    assign code_prev = {prev_q.activate_code_live,
                        prev_q.deactivate_code_live};

    // inband code edge detection, one per code flag
    genvar g;
    generate
        for (g = 0; g < line_irq_pkg::CODE_FLAG_COUNT; g++)
        begin : g_code
            assign code_set[g] = edge_select_q ?
                (code_live[g] ^ code_prev[g]) :
                (code_live[g] & ~code_prev[g]);
        end
    endgenerate

    // line event sources; rising edges so a held error counts once
    always_comb
    begin
        line_set = '0;
        line_set[line_irq_pkg::BIT_SYS_VIOL] =
            sync2_q.system_violation & ~prev_q.system_violation;
        line_set[line_irq_pkg::BIT_LINE_VIOL] =
            sync2_q.line_violation & ~prev_q.line_violation;
        line_set[line_irq_pkg::BIT_SYS_ZEROS] =
            sync2_q.system_zeros & ~prev_q.system_zeros;
        line_set[line_irq_pkg::BIT_LINE_ZEROS] =
            sync2_q.line_zeros & ~prev_q.line_zeros;
        line_set[line_irq_pkg::BIT_PATTERN_ERR] =
            sync2_q.pattern_error & ~prev_q.pattern_error;
        line_set[line_irq_pkg::BIT_COUNT_OVF] = count_wrap;
    end

    assign code_clr = hit_write(req, line_irq_pkg::ADDR_CODE_FLAGS) ?
        req.wdata[line_irq_pkg::CODE_FLAG_COUNT-1:0] : '0;
    assign line_clr = hit_write(req, line_irq_pkg::ADDR_LINE_FLAGS) ?
        req.wdata[line_irq_pkg::LINE_FLAG_COUNT-1:0] : '0;

    // sticky flags; a set in the clearing cycle wins so no event is lost
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            code_flags_q <= line_irq_pkg::RESET_FLAGS[1:0];
            line_flags_q <= line_irq_pkg::RESET_FLAGS[5:0];
        end
        else
        begin
            code_flags_q <= (code_flags_q & ~code_clr) | code_set;
            line_flags_q <= (line_flags_q & ~line_clr) | line_set;
        end
    end

    // enabled flags drive the level interrupt
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(line_flags_q & line_enable_q[5:0])
                   | |(code_flags_q & code_enable_q[1:0]);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (req.addr)
            line_irq_pkg::ADDR_LINE_FLAGS: rdata_d = {2'b00, line_flags_q};
            line_irq_pkg::ADDR_CODE_FLAGS: rdata_d = {6'h00, code_flags_q};
            line_irq_pkg::ADDR_LIVE_ONE: rdata_d = {6'h00, code_live};
            line_irq_pkg::ADDR_CODE_ENABLE: rdata_d = code_enable_q;
            line_irq_pkg::ADDR_LINE_ENABLE: rdata_d = line_enable_q;
            line_irq_pkg::ADDR_CONFIG: rdata_d = {7'h00, edge_select_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            reg_rdata_o <= req.read ? rdata_d : 8'h00;
        end
    end

endmodule

`default_nettype wire

// File: tb/line_irq_monitor.sv
// port checker for the line event interrupt status block
`timescale 1ns/1ps
`default_nettype none
module line_irq_monitor #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire line_irq_pkg::line_events_t events_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o
);
    logic [2:0] ev_age_q;
    logic [2:0] wr_age_q;
    logic en_seen_q;
    line_irq_pkg::line_events_t ev_prev_q;
    // ages saturate, so long quiet spells cost no width
    // reset keeps the ages known before the first event or write
    always_ff @(posedge clock_i)
    begin
        ev_prev_q <= events_i;
        if (!rst_n_i)
        begin
            ev_age_q <= 3'h7;
            wr_age_q <= 3'h7;
        end
        else
        begin
            if (events_i != ev_prev_q) ev_age_q <= 3'h0;
            else if (ev_age_q != 3'h7) ev_age_q <= ev_age_q + 3'h1;
            if (reg_write_i) wr_age_q <= 3'h0;
            else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
        end
    end
    // sticky: once any enable is written nonzero we stop judging the mask
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i) en_seen_q <= 1'b0;
        else if (reg_write_i && reg_wdata_i != 8'h00 &&
            (reg_addr_i == line_irq_pkg::ADDR_CODE_ENABLE ||
            reg_addr_i == line_irq_pkg::ADDR_LINE_ENABLE)) en_seen_q <= 1'b1;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    rdata_idle_a: assert property (
        !$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    line_rsvd_a: assert property ($past(reg_read_i) &&
        $past(reg_addr_i) == line_irq_pkg::ADDR_LINE_FLAGS
        |-> reg_rdata_o[7:6] == 2'h0) else $error("line flags top bits set");
    code_rsvd_a: assert property ($past(reg_read_i) &&
        $past(reg_addr_i) == line_irq_pkg::ADDR_CODE_FLAGS
        |-> reg_rdata_o[7:2] == 6'h00) else $error("code flags top bits set");
    unmapped_rd_a: assert property ($past(reg_read_i) &&
        $past(reg_addr_i) == 12'h7e5 |-> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    irq_start_a: assert property (
        $rose(rst_n_i) |-> !irq_o) else $error("interrupt high after reset");
    irq_mask_a: assert property (
        !en_seen_q |-> !irq_o) else $error("interrupt with no enable");
    irq_rise_a: assert property ($rose(irq_o) |->
        ev_age_q <= 3'h6 || wr_age_q <= 3'h3)
        else $error("interrupt rose without cause");
    irq_fall_a: assert property (
        $fell(irq_o) |-> wr_age_q <= 3'h3)
        else $error("interrupt fell without write");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the line event interrupt status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    line_irq_pkg::line_events_t events_i = '0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic irq_o;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 clock_i = ~clock_i;
    // short counter so a wrap takes sixteen error edges
    line_event_interrupt_status #(.COUNT_WIDTH(4)) i_line_event_interrupt_status (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .events_i(events_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1 `CHK(reg_rdata_o, exp)
    endtask
    task automatic chk_irq(input logic exp);
        idle(2);
        #1 `CHK(irq_o, exp)
    endtask
    // toggle one live input, then let the two-stage sync settle
    task automatic flip(input int b);
        @(posedge clock_i);
        events_i[b] <= ~events_i[b];
        idle(6);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            results();
        end
    end
    initial
    begin
        idle(10);
        rst_n_i <= 1'b1;
        rd(line_irq_pkg::ADDR_CODE_FLAGS, 8'h00);
        rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'h00);
        rd(line_irq_pkg::ADDR_LINE_ENABLE, 8'h00);
        rd(12'h7e5, 8'h00);
        // masked flag latches but stays off the interrupt
        flip(4);
        flip(4);
        rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'h20);
        chk_irq(1'b0);
        wr(line_irq_pkg::ADDR_LINE_ENABLE, 8'h3f);
        chk_irq(1'b1);
        wr(line_irq_pkg::ADDR_LINE_FLAGS, 8'h20);
        chk_irq(1'b0);
        for (int i = 0; i < 5; i++)
        begin
            flip(i);
            rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'(1 << (i + 1)));
            chk_irq(1'b1);
            wr(line_irq_pkg::ADDR_LINE_FLAGS, 8'h00);
            rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'(1 << (i + 1)));
            wr(line_irq_pkg::ADDR_LINE_FLAGS, 8'(1 << (i + 1)));
            flip(i);
            rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'h00);
            chk_irq(1'b0);
        end
        wr(line_irq_pkg::ADDR_CODE_ENABLE, 8'h03);
        for (int e = 0; e < 2; e++)
        begin
            wr(line_irq_pkg::ADDR_CONFIG, 8'(e));
            for (int j = 0; j < 2; j++)
            begin
                flip(5 + j);
                rd(line_irq_pkg::ADDR_CODE_FLAGS, 8'(1 << j));
                rd(line_irq_pkg::ADDR_LIVE_ONE, 8'(1 << j));
                chk_irq(1'b1);
                wr(line_irq_pkg::ADDR_CODE_FLAGS, 8'(1 << j));
                flip(5 + j);
                rd(line_irq_pkg::ADDR_CODE_FLAGS, 8'(e << j));
                wr(line_irq_pkg::ADDR_CODE_FLAGS, 8'h03);
            end
        end
        chk_irq(1'b0);
        rd(line_irq_pkg::ADDR_CONFIG, 8'h01);
        rd(line_irq_pkg::ADDR_CODE_ENABLE, 8'h03);
        // fifteen error edges so far after this loop, no wrap yet
        repeat (14)
        begin
            flip(0);
            flip(0);
        end
        rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'h02);
        flip(0);
        rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'h03);
        chk_irq(1'b1);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        rd(line_irq_pkg::ADDR_LINE_FLAGS, 8'h00);
        results();
    end
endmodule
bind line_event_interrupt_status line_irq_monitor #(
    .COUNT_WIDTH(COUNT_WIDTH)) i_line_irq_monitor (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .events_i(events_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
`default_nettype wire
